// ==== rtl/sdma_defs.vh ====
/*
  Register indices, field positions and reset values for the
  double-buffered serial DMA control block.
  Assumes a 32-bit AHB-Lite slave, one register to an aligned word.
*/
`ifndef SDMA_DEFS_VH
`define SDMA_DEFS_VH

// Register indices; byte address is four times the index
`define DMA_CONTROL_IDX    16'h4418
`define DMA_STATUS_IDX     16'h4416
`define IRQ_STATUS_IDX     16'h441a
`define IRQ_MASK_IDX       16'h441c

// dma_control fields
`define CTL_RX_A_LOAD      0
`define CTL_RX_B_LOAD      1
`define CTL_TX_A_LOAD      2
`define CTL_TX_B_LOAD      3
`define CTL_RX_DMA_RESET   4
`define CTL_TX_DMA_RESET   5

// dma_status fields
`define STS_RX_A_ACTIVE    0
`define STS_RX_B_ACTIVE    1
`define STS_TX_A_ACTIVE    2
`define STS_TX_B_ACTIVE    3
`define STS_RX_A_OVERRUN   4
`define STS_RX_B_OVERRUN   5

// Interrupt status / mask fields
`define IRQ_RX_A_DONE      0
`define IRQ_RX_B_DONE      1
`define IRQ_TX_A_DONE      2
`define IRQ_TX_B_DONE      3
`define IRQ_RX_A_OVERRUN   4
`define IRQ_RX_B_OVERRUN   5
`define IRQ_WIDTH          6

// Reset values
`define DMA_CONTROL_RST    16'h0000
`define DMA_STATUS_RST     16'h0000
`define IRQ_MASK_RST       6'h00

// AHB encodings
`define HTRANS_NONSEQ      2'h2
`define HTRANS_SEQ         2'h3

`endif

// ==== rtl/sticky_irq.v ====
/*
  Sticky interrupt status bits, write-one-to-clear, gated by a mask onto
  one level interrupt output.
  Assumes events and clears are one-cycle pulses on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none

module sticky_irq #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         sys_clk_in,
  input  wire         sys_rst_in,
  // Events, clears and mask
  input  wire [W-1:0] evt_in,
  input  wire [W-1:0] clr_in,
  input  wire [W-1:0] mask_in,
  // Status and interrupt
  output wire [W-1:0] status_out,
  output wire         irq_out
);

  reg [W-1:0] status_r;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // Set wins over a clear in the same cycle
      always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          status_r[i] <= 1'b0;
        end else begin
          status_r[i] <= evt_in[i] | (status_r[i] & ~clr_in[i]);
        end
      end
    end
  endgenerate

  assign status_out = status_r;
  assign irq_out    = |(status_r & mask_in);

endmodule

`default_nettype wire

// ==== rtl/dual_buf_chan.v ====
/*
  One DMA direction with two buffers A and B: load bits, active buffer,
  alternation between buffers and per-buffer overrun flags.
  Assumes done and overrun pulses come from the DMA engine and FIFO
  on the same clock. Bit 0 is buffer A, bit 1 is buffer B.
*/
`timescale 1ns/1ns
`default_nettype none

module dual_buf_chan (
  // Clock and reset
  input  wire       sys_clk_in,
  input  wire       sys_rst_in,
  // Software side
  input  wire [1:0] load_wr_in,
  input  wire       chan_rst_in,
  // Engine side
  input  wire       done_in,
  input  wire       overrun_in,
  output reg  [1:0] start_out,
  output reg  [1:0] done_evt_out,
  output reg  [1:0] ovf_evt_out,
  // State
  output wire [1:0] load_out,
  output wire [1:0] active_out,
  output wire [1:0] ovf_out
);

  reg [1:0] load_r;
  reg [1:0] load_nxt;
  reg [1:0] act_r;
  reg [1:0] act_nxt;
  reg [1:0] ovf_r;
  reg [1:0] ovf_nxt;
  reg       next_r;
  reg       next_nxt;
  reg       tgt;

  always @* begin
    load_nxt     = load_r | load_wr_in;
    act_nxt      = act_r;
    next_nxt     = next_r;
    start_out    = 2'b00;
    done_evt_out = 2'b00;
    ovf_evt_out  = 2'b00;
    ovf_nxt      = ovf_r & ~load_wr_in;
    tgt          = (act_r != 2'b00) ? act_r[1] : next_r;
    if (overrun_in) begin
      ovf_nxt[tgt]     = 1'b1;
      ovf_evt_out[tgt] = 1'b1;
    end
    if (done_in && (act_r != 2'b00)) begin
      done_evt_out = act_r;
      load_nxt     = (load_r & ~act_r) | load_wr_in;
      act_nxt      = 2'b00;
    end
    // One buffer at a time; the next-to-load buffer goes first
    if (act_nxt == 2'b00) begin
      if (load_nxt[next_nxt]) begin
        act_nxt[next_nxt]   = 1'b1;
        start_out[next_nxt] = 1'b1;
        next_nxt            = ~next_nxt;
      end else if (load_nxt[~next_nxt]) begin
        act_nxt[~next_nxt]   = 1'b1;
        start_out[~next_nxt] = 1'b1;
      end
    end
    if (chan_rst_in) begin
      load_nxt     = 2'b00;
      act_nxt      = 2'b00;
      ovf_nxt      = 2'b00;
      next_nxt     = 1'b0;
      start_out    = 2'b00;
      done_evt_out = 2'b00;
      ovf_evt_out  = 2'b00;
    end
  end

  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      load_r <= 2'b00;
      act_r  <= 2'b00;
      ovf_r  <= 2'b00;
      next_r <= 1'b0;
    end else begin
      load_r <= load_nxt;
      act_r  <= act_nxt;
      ovf_r  <= ovf_nxt;
      next_r <= next_nxt;
    end
  end

  assign load_out   = load_r;
  assign active_out = act_r;
  assign ovf_out    = ovf_r;

endmodule

`default_nettype wire

// ==== rtl/serial_dual_buffer_dma.v ====
/*
  Control and status for the double-buffered transmit and receive DMA of a
  serial controller, reached over AHB-Lite, with a masked interrupt.
  Assumes one AHB master with this slave alone on the bus, and a DMA
  engine and receive FIFO on the same clock.
*/
// Register access over AHB-Lite is this design's own decision.
// Contract
// - Writing TX B load starts transmit buffer B
// - Writing TX A load starts transmit buffer A
// - Writing RX B load starts receive buffer B
// - Writing RX A load starts receive buffer A
// - Load bit clears when its DMA completes
// - Writing zero to load bits does nothing
// - Load bit reads one while active or pending
// - FIFO overrun into buffer B sets B overrun
// - FIFO overrun into buffer A sets A overrun
// - Overrun flag clears on load or RX reset
// - TX active bits show buffer in use
// - RX active bits show buffer in use
// - RX DMA reset bit resets, then self-clears
`timescale 1ns/1ns
`default_nettype none
`include "sdma_defs.vh"

module serial_dual_buffer_dma (
  // Clock and reset
  input  wire        sys_clk_in,
  input  wire        sys_rst_in,
  // AHB-Lite slave
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output reg  [31:0] hrdata_out,
  output wire        hreadyout_out,
  output wire        hresp_out,
  // Transmit engine
  input  wire        tx_done_in,
  output wire [1:0]  tx_start_out,
  output wire        tx_dma_reset_out,
  // Receive engine and FIFO
  input  wire        rx_done_in,
  input  wire        rx_overrun_in,
  output wire [1:0]  rx_start_out,
  output wire        rx_dma_reset_out,
  // Interrupt
  output wire        irq_out
);

  localparam [15:0] CTL_IDX  = `DMA_CONTROL_IDX;
  localparam [15:0] STS_IDX  = `DMA_STATUS_IDX;
  localparam [15:0] ISTS_IDX = `IRQ_STATUS_IDX;
  localparam [15:0] MASK_IDX = `IRQ_MASK_IDX;

  // Address phase capture
  reg        wr_pend_r;
  reg [15:0] wr_idx_r;
  wire       take;
  wire [15:0] a_idx;
  wire       a_mapped;

  assign take     = hsel_in & hready_in & htrans_in[1];
  assign a_idx    = haddr_in[17:2];
  assign a_mapped = (haddr_in[31:18] == 14'h0000) & (haddr_in[1:0] == 2'b00);

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 16'h0000;
    end else begin
      wr_pend_r <= take & hwrite_in & a_mapped;
      wr_idx_r  <= a_idx;
    end
  end

  // Data phase write strobes
  wire       wr_ctl  = wr_pend_r & (wr_idx_r == CTL_IDX);
  wire       wr_ists = wr_pend_r & (wr_idx_r == ISTS_IDX);
  wire       wr_mask = wr_pend_r & (wr_idx_r == MASK_IDX);

  // Only ones written to load bits take effect
  wire [1:0] rx_load_wr = wr_ctl ? {hwdata_in[`CTL_RX_B_LOAD], hwdata_in[`CTL_RX_A_LOAD]}
                                 : 2'b00;
  wire [1:0] tx_load_wr = wr_ctl ? {hwdata_in[`CTL_TX_B_LOAD], hwdata_in[`CTL_TX_A_LOAD]}
                                 : 2'b00;

  // Reset bits act as one-cycle pulses and read as zero
  assign rx_dma_reset_out = wr_ctl & hwdata_in[`CTL_RX_DMA_RESET];
  assign tx_dma_reset_out = wr_ctl & hwdata_in[`CTL_TX_DMA_RESET];

  // Channels
  wire [1:0] rx_load;
  wire [1:0] rx_act;
  wire [1:0] rx_ovf;
  wire [1:0] rx_done_evt;
  wire [1:0] rx_ovf_evt;
  wire [1:0] tx_load;
  wire [1:0] tx_act;
  wire [1:0] tx_done_evt;

  dual_buf_chan u_rx (
    .sys_clk_in   (sys_clk_in),
    .sys_rst_in   (sys_rst_in),
    .load_wr_in   (rx_load_wr),
    .chan_rst_in  (rx_dma_reset_out),
    .done_in      (rx_done_in),
    .overrun_in   (rx_overrun_in),
    .start_out    (rx_start_out),
    .done_evt_out (rx_done_evt),
    .ovf_evt_out  (rx_ovf_evt),
    .load_out     (rx_load),
    .active_out   (rx_act),
    .ovf_out      (rx_ovf)
  );

  dual_buf_chan u_tx (
    .sys_clk_in   (sys_clk_in),
    .sys_rst_in   (sys_rst_in),
    .load_wr_in   (tx_load_wr),
    .chan_rst_in  (tx_dma_reset_out),
    .done_in      (tx_done_in),
    .overrun_in   (1'b0),
    .start_out    (tx_start_out),
    .done_evt_out (tx_done_evt),
    .ovf_evt_out  (),
    .load_out     (tx_load),
    .active_out   (tx_act),
    .ovf_out      ()
  );

  // Interrupt mask and sticky status
  reg  [`IRQ_WIDTH-1:0] mask_r;
  wire [`IRQ_WIDTH-1:0] irq_sts;
  wire [`IRQ_WIDTH-1:0] irq_evt;

  assign irq_evt = {rx_ovf_evt, tx_done_evt, rx_done_evt};

  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mask_r <= `IRQ_MASK_RST;
    end else if (wr_mask) begin
      mask_r <= hwdata_in[`IRQ_WIDTH-1:0];
    end
  end

  sticky_irq #(
    .W (`IRQ_WIDTH)
  ) u_irq (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .evt_in     (irq_evt),
    .clr_in     (wr_ists ? hwdata_in[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}}),
    .mask_in    (mask_r),
    .status_out (irq_sts),
    .irq_out    (irq_out)
  );

  // Register views
  wire [15:0] ctl_view = {12'h000, tx_load, rx_load};
  wire [15:0] sts_view = {10'h000, rx_ovf, tx_act, rx_act};

  // Read data registered in the address phase
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hrdata_out <= 32'h00000000;
    end else if (take & ~hwrite_in) begin
      if (!a_mapped) begin
        hrdata_out <= 32'h00000000;
      end else begin
        case (a_idx)
          CTL_IDX:  hrdata_out <= {16'h0000, ctl_view};
          STS_IDX:  hrdata_out <= {16'h0000, sts_view};
          ISTS_IDX: hrdata_out <= {26'h0000000, irq_sts};
          MASK_IDX: hrdata_out <= {26'h0000000, mask_r};
          default:  hrdata_out <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== verif/dma_engine_model.sv ====
/* Behavioural DMA engine for one direction: finishes a buffer DLY cycles
   after its start pulse. Assumes start and reset pulses on the system clock. */
`timescale 1ns/1ns
`default_nettype none
module dma_engine_model #(
  parameter DLY = 10
) (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  // Control side
  input  wire logic [1:0] start_in,
  input  wire logic       dma_reset_in,
  output var  logic       done_out
);
  logic [7:0] cnt_r;
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r    <= 8'h00;
      done_out <= 1'b0;
    end else begin
      done_out <= (cnt_r == 8'h01) && !dma_reset_in;
      if (dma_reset_in) cnt_r <= 8'h00;
      else if (|start_in) cnt_r <= DLY;
      else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== verif/sdma_checker_assertions.sv ====
/* Checker for the dual buffer DMA control block.
   Assumes a bind to the top module, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module sdma_checker (
  // Clock, reset, bus
  input wire logic        sys_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  // Engines and interrupt
  input wire logic        tx_done_in,
  input wire logic [1:0]  tx_start_out,
  input wire logic        tx_dma_reset_out,
  input wire logic        rx_done_in,
  input wire logic [1:0]  rx_start_out,
  input wire logic        rx_dma_reset_out,
  input wire logic        irq_out
);
  logic wr_q, wr_ctl_q, rx_busy_r, tx_busy_r, take;
  assign take = hsel_in & hready_in & htrans_in[1] & hwrite_in;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_q      <= 1'b0;
      wr_ctl_q  <= 1'b0;
      rx_busy_r <= 1'b0;
      tx_busy_r <= 1'b0;
    end else begin
      wr_q     <= take;
      wr_ctl_q <= take && (haddr_in == 32'h0001_1060);
      if (rx_dma_reset_out) rx_busy_r <= 1'b0;
      else if (|rx_start_out) rx_busy_r <= 1'b1;
      else if (rx_done_in) rx_busy_r <= 1'b0;
      if (tx_dma_reset_out) tx_busy_r <= 1'b0;
      else if (|tx_start_out) tx_busy_r <= 1'b1;
      else if (tx_done_in) tx_busy_r <= 1'b0;
    end
  end
  sequence s_rx_load;
    wr_ctl_q && !rx_busy_r && !hwdata_in[4] && (hwdata_in[1:0] != 2'h0);
  endsequence
  sequence s_tx_load;
    wr_ctl_q && !tx_busy_r && !hwdata_in[5] && (hwdata_in[3:2] != 2'h0);
  endsequence
  AST_RX_START: assert property (s_rx_load |-> rx_start_out != 2'h0)
    else $error("rx load did not start");
  AST_TX_START: assert property (s_tx_load |-> tx_start_out != 2'h0)
    else $error("tx load did not start");
  AST_RX_ONE: assert property ($onehot0(rx_start_out))
    else $error("two rx starts");
  AST_TX_ONE: assert property ($onehot0(tx_start_out))
    else $error("two tx starts");
  AST_RX_HOLD: assert property (rx_busy_r && !rx_done_in |-> rx_start_out == 2'h0)
    else $error("rx start while busy");
  AST_ZERO_WR: assert property (wr_ctl_q && hwdata_in[1:0] == 2'h0 && !rx_done_in
    |-> rx_start_out == 2'h0)
    else $error("zero write started rx");
  AST_RX_RST: assert property (wr_ctl_q && hwdata_in[4] |-> rx_dma_reset_out ##1 !rx_dma_reset_out)
    else $error("rx reset pulse wrong");
  AST_TX_RST: assert property (wr_ctl_q && hwdata_in[5] |-> tx_dma_reset_out)
    else $error("tx reset missing");
  AST_IRQ_FALL: assert property ($fell(irq_out) |-> $past(wr_q))
    else $error("irq fell without write");
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
/* Self-checking bench for the dual buffer DMA block over AHB-Lite.
   Assumes the design files and the engine model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam CTL = 32'h0001_1060, STS = 32'h0001_1058;
  localparam IST = 32'h0001_1068, IMK = 32'h0001_1070;
  logic        clk, rst, hwrite, tx_done, rx_done, ovf, hready, irq, tx_rst, rx_rst;
  logic [1:0]  htrans, tx_start, rx_start;
  logic [31:0] haddr, hwdata, hrdata, rd;
  integer      error_cnt, n_checks, cyc;
  serial_dual_buffer_dma serial_dual_buffer_dma_inst (.sys_clk_in(clk), .sys_rst_in(rst),
    .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(), .tx_done_in(tx_done), .tx_start_out(tx_start),
    .tx_dma_reset_out(tx_rst), .rx_done_in(rx_done), .rx_overrun_in(ovf),
    .rx_start_out(rx_start), .rx_dma_reset_out(rx_rst), .irq_out(irq));
  dma_engine_model #(.DLY(20)) rx_model_inst (.sys_clk_in(clk), .sys_rst_in(rst),
    .start_in(rx_start), .dma_reset_in(rx_rst), .done_out(rx_done));
  dma_engine_model #(.DLY(10)) tx_model_inst (.sys_clk_in(clk), .sys_rst_in(rst),
    .start_in(tx_start), .dma_reset_in(tx_rst), .done_out(tx_done));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt = error_cnt + 1;
      end_of_test;
    end
  end
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task check(input [31:0] got, input [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task ahb(input [31:0] a, input w, input [31:0] d);
    @(posedge clk);
    htrans <= 2'h2; haddr <= a; hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task wr(input [31:0] a, input [31:0] d); ahb(a, 1'b1, d); endtask
  task rdchk(input [31:0] a, input [31:0] e); ahb(a, 1'b0, 0); check(rd, e); endtask
  task poll(input [31:0] a, input [31:0] e);
    integer i;
    ahb(a, 1'b0, 0);
    for (i = 0; i < 60 && rd !== e; i++) ahb(a, 1'b0, 0);
    check(rd, e);
  endtask
  task pulse_ovf;
    @(posedge clk) ovf <= 1'b1;
    @(posedge clk) ovf <= 1'b0;
  endtask
  task t_regs;
    rdchk(CTL, 0);
    rdchk(STS, 0);
    wr(STS, 32'h3f);
    rdchk(STS, 0);
    rdchk(IMK, 0);
    rdchk(32'h100, 0);
    $display("t_regs done");
  endtask
  task t_rx;
    wr(CTL, 3);
    rdchk(CTL, 3);
    rdchk(STS, 1);
    poll(STS, 2);
    rdchk(CTL, 2);
    poll(CTL, 0);
    rdchk(STS, 0);
    rdchk(IST, 3);
    $display("t_rx done");
  endtask
  task t_tx;
    wr(CTL, 0);
    rdchk(CTL, 0);
    wr(CTL, 8);
    rdchk(STS, 8);
    poll(CTL, 0);
    wr(CTL, 4);
    rdchk(STS, 4);
    poll(STS, 0);
    wr(CTL, 8);
    wr(CTL, 32'h20);
    rdchk(CTL, 0);
    rdchk(STS, 0);
    $display("t_tx done");
  endtask
  task t_ovf;
    pulse_ovf;
    rdchk(STS, 32'h10);
    wr(CTL, 1);
    rdchk(STS, 1);
    pulse_ovf;
    rdchk(STS, 32'h11);
    poll(CTL, 0);
    pulse_ovf;
    rdchk(STS, 32'h30);
    wr(CTL, 2);
    rdchk(STS, 32'h12);
    wr(CTL, 32'h10);
    rdchk(CTL, 0);
    rdchk(STS, 0);
    $display("t_ovf done");
  endtask
  task t_irq;
    wr(IMK, 0);
    check(irq, 0);
    wr(IMK, 32'h3f);
    rdchk(IMK, 32'h3f);
    check(irq, 1);
    wr(IST, 32'h3f);
    rdchk(IST, 0);
    check(irq, 0);
    $display("t_irq done");
  endtask
  initial begin
    error_cnt = 0; n_checks = 0; cyc = 0; rst = 1'b1; ovf = 1'b0; htrans = 2'h0;
    haddr = 0; hwrite = 1'b0; hwdata = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs; t_rx; t_tx; t_ovf; t_irq;
    end_of_test;
  end
endmodule
bind serial_dual_buffer_dma sdma_checker sdma_checker_inst (.sys_clk_in, .sys_rst_in,
  .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .tx_done_in,
  .tx_start_out, .tx_dma_reset_out, .rx_done_in, .rx_start_out, .rx_dma_reset_out,
  .irq_out);
`default_nettype wire
